// File: scspc_card_model.sv
// card side of the pads: data line with pull resistors, other pad levels from the bench
`timescale 1ns/100ps
module scspc_card_model (
  input wire logic pclk,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_up,
  input wire logic pull_dn,
  input wire logic [3:0] card_lvl,
  output logic data_line,
  output logic [3:0] card_pins
);
  initial data_line = 1'b0;
  assign card_pins = card_lvl;
  // a floating line keeps changing so that a stale level never reads back as a match
  always @(posedge pclk) begin
    if (pad_oe) data_line <= pad_out;
    else if (pull_up) data_line <= 1'b1;
    else if (pull_dn) data_line <= 1'b0;
    else data_line <= ~data_line;
  end
endmodule : scspc_card_model

// File: scspc_data_pad_drive.sv
// output stage of the card data pad: push-pull, sink-only and boosted release
`timescale 1ns/100ps
module scspc_data_pad_drive (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic drive_gate,
  input wire logic boost,
  input wire logic sink,
  input wire logic drive_value,
  output logic pad_out,
  output logic pad_oe
);
  import scspc_pkg::*;
  scspc_drv_s r_reg;
  scspc_drv_s r_next;

  always_comb begin
    r_next = r_reg;
    r_next.prev = drive_value;
    r_next.out = drive_value;
    if (!active || !drive_gate) begin
      r_next.oe = 1'b0;
    end else if (boost) begin
      // one cycle of active high speeds the rising edge, then the pull-up holds
      r_next.oe = !drive_value || !r_reg.prev;
    end else if (sink) begin
      r_next.oe = !drive_value;
    end else begin
      r_next.oe = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pad_out = r_reg.out;
  assign pad_oe = r_reg.oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_boost_pulse: assert property (
    (active && drive_gate && boost && drive_value && !r_reg.prev)
    |=> (pad_oe && pad_out) ##1 (!(pad_oe && pad_out) || !$past(boost)))
    else $error("boosted release high not exactly one cycle");
  chk_sink_only: assert property (
    (active && drive_gate && !boost && sink) |=> (pad_oe == !$past(drive_value)))
    else $error("sink-only drive wrong");
  chk_gate_off: assert property (
    (!active || !drive_gate) |=> !pad_oe)
    else $error("pad driven while drive gate clear");
  chk_push_pull: assert property (
    (active && drive_gate && !boost && !sink) |=> (pad_oe && pad_out == $past(drive_value)))
    else $error("push-pull level wrong");
  cov_boost_pulse: cover property (active && drive_gate && boost && drive_value && !r_reg.prev);
endmodule : scspc_data_pad_drive

// File: scspc_pad_ctrl.sv
// APB register block and pad control for the smart card synchronous pads
//
// Operation
// - bit 13 enables data pad receiver
// - bit 12 enables data pad driver
// - boosted release: low, one-cycle high, release
// - sink-only: drive zeros, release ones
// - bit 9 turns on pull-up
// - bit 8 turns on pull-down
// - bit 1 reads data pin in sync mode
// - bit 0 sets data pin level
// - all-pads register accesses every pad at once
// - all-pads bit 5 is C8 pad
// - all-pads bit 4 is C4 pad
// - all-pads bit 3 is data pad
// - all-pads bit 2 is clock pad
// - all-pads bit 1 is reset pad
// - supply gate clear masks regulator select
// - supply gate set passes regulator select
// - block works only while power gate set, except reset, clock, C4 and C8 drive values
`timescale 1ns/100ps
module scspc_pad_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [scspc_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scspc_pkg::APB_DW-1:0] pwdata,
  output logic [scspc_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_mode_sel,
  input wire logic data_pad_in,
  input wire logic clk_pad_in,
  input wire logic rst_pad_in,
  input wire logic c4_pad_in,
  input wire logic c8_pad_in,
  output logic data_pad_out,
  output logic data_pad_oe,
  output logic data_pad_rx_en,
  output logic data_pad_pull_up,
  output logic data_pad_pull_dn,
  output logic rst_drive_value,
  output logic clk_drive_value,
  output logic c4_drive_value,
  output logic c8_drive_value,
  output logic [scspc_pkg::SUP_W-1:0] regulator_select
);
  import scspc_pkg::*;

  scspc_state_s r_reg;
  scspc_state_s r_next;
  logic [NPADS-1:0] pin_sync;
  logic [NPADS-1:0] sample;
  logic active;
  logic hit_data;
  logic hit_all;
  logic hit_ctrl;
  logic setup;
  logic wr_fire;
  logic [APB_DW-1:0] rdata;

  scspc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({c8_pad_in, c4_pad_in, data_pad_in, clk_pad_in, rst_pad_in}),
    .pin_sync(pin_sync)
  );

  // data pad drive and pad samples follow software only in synchronous mode and with the block powered
  assign active = r_reg.power_gate && sync_mode_sel;

  // the data sample is blocked when its input buffer is gated off
  always_comb begin
    sample = pin_sync & {NPADS{active}};
    sample[PAD_DATA] = pin_sync[PAD_DATA] && active && r_reg.rx_gate;
  end

  assign hit_data = (paddr == OFF_DATA_PAD);
  assign hit_all = (paddr == OFF_ALL_PADS);
  assign hit_ctrl = (paddr == OFF_BLOCK_CTRL);
  assign setup = psel && penable && !r_reg.pready;
  // writes land only on the edge where the master sees pready
  assign wr_fire = psel && penable && pwrite && r_reg.pready && !r_reg.pslverr;

  always_comb begin
    rdata = '0;
    if (hit_data) begin
      rdata[DP_RX_GATE] = r_reg.rx_gate;
      rdata[DP_TX_GATE] = r_reg.tx_gate;
      rdata[DP_BOOST] = r_reg.boost;
      rdata[DP_SINK] = r_reg.sink;
      rdata[DP_PULL_UP] = r_reg.pull_up;
      rdata[DP_PULL_DN] = r_reg.pull_dn;
      rdata[DP_SAMPLE] = sample[PAD_DATA];
      rdata[DP_DRIVE] = r_reg.drive[PAD_DATA];
    end else if (hit_all) begin
      rdata[AP_C8:AP_RST] = sample;
      rdata[AP_SUPPLY] = r_reg.supply_gate;
    end else if (hit_ctrl) begin
      rdata[BC_POWER] = r_reg.power_gate;
      rdata[BC_SUP_LSB +: SUP_W] = r_reg.supply_sel;
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    // one wait state: pready comes in the second access cycle
    if (setup) begin
      r_next.pready = 1'b1;
      r_next.pslverr = !(hit_data || hit_all || hit_ctrl);
      r_next.prdata = pwrite ? '0 : rdata;
    end
    if (wr_fire && hit_data) begin
      r_next.rx_gate = pwdata[DP_RX_GATE];
      r_next.tx_gate = pwdata[DP_TX_GATE];
      r_next.boost = pwdata[DP_BOOST];
      r_next.sink = pwdata[DP_SINK];
      r_next.pull_up = pwdata[DP_PULL_UP];
      r_next.pull_dn = pwdata[DP_PULL_DN];
      r_next.drive[PAD_DATA] = pwdata[DP_DRIVE];
    end
    // pad setup in the data pad register is assumed done before this write
    if (wr_fire && hit_all) begin
      r_next.drive = pwdata[AP_C8:AP_RST];
      r_next.supply_gate = pwdata[AP_SUPPLY];
    end
    if (wr_fire && hit_ctrl) begin
      r_next.power_gate = pwdata[BC_POWER];
      r_next.supply_sel = pwdata[BC_SUP_LSB +: SUP_W];
    end
    // regulators off unless the block is powered and the supply gate is set
    if (r_reg.supply_gate && r_reg.power_gate) begin
      r_next.reg_sel = r_reg.supply_sel;
    end else begin
      r_next.reg_sel = '0;
    end
    r_next.rx_en = r_reg.rx_gate && r_reg.power_gate;
    r_next.pu_out = r_reg.pull_up && r_reg.power_gate;
    r_next.pd_out = r_reg.pull_dn && r_reg.power_gate;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  scspc_data_pad_drive u_drive (
    .pclk(pclk),
    .presetn(presetn),
    .active(active),
    .drive_gate(r_reg.tx_gate),
    .boost(r_reg.boost),
    .sink(r_reg.sink),
    .drive_value(r_reg.drive[PAD_DATA]),
    .pad_out(data_pad_out),
    .pad_oe(data_pad_oe)
  );

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign data_pad_rx_en = r_reg.rx_en;
  assign data_pad_pull_up = r_reg.pu_out;
  assign data_pad_pull_dn = r_reg.pd_out;
  assign rst_drive_value = r_reg.drive[0];
  assign clk_drive_value = r_reg.drive[1];
  assign c4_drive_value = r_reg.drive[3];
  assign c8_drive_value = r_reg.drive[4];
  assign regulator_select = r_reg.reg_sel;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_wait: assert property (
    setup |=> pready)
    else $error("pready not one cycle after access start");
  chk_apb_pulse: assert property (
    pready |=> !pready)
    else $error("pready held more than one cycle");
  chk_apb_unmapped: assert property (
    (setup && !hit_data && !hit_all && !hit_ctrl) |=> (pready && pslverr))
    else $error("unmapped access not flagged");
  chk_rx_gate_write: assert property (
    (wr_fire && hit_data && r_reg.power_gate)
    |=> ##1 (data_pad_rx_en == $past(pwdata[DP_RX_GATE], 2)))
    else $error("receive gate write not on pad");
  chk_pull_up_write: assert property (
    (wr_fire && hit_data && r_reg.power_gate)
    |=> ##1 (data_pad_pull_up == $past(pwdata[DP_PULL_UP], 2)))
    else $error("pull-up write not on pad");
  chk_pull_dn_write: assert property (
    (wr_fire && hit_data && r_reg.power_gate)
    |=> ##1 (data_pad_pull_dn == $past(pwdata[DP_PULL_DN], 2)))
    else $error("pull-down write not on pad");
  chk_all_pads_write: assert property (
    (wr_fire && hit_all)
    |=> ({c8_drive_value, c4_drive_value, r_reg.drive[PAD_DATA], clk_drive_value,
          rst_drive_value} == $past(pwdata[AP_C8:AP_RST]))
        && (r_reg.supply_gate == $past(pwdata[AP_SUPPLY])))
    else $error("all pads write not applied");
  chk_all_pads_read: assert property (
    (setup && !pwrite && hit_all) |=> (prdata[AP_C8:AP_RST] == $past(sample)))
    else $error("all pads read wrong samples");
  chk_supply_mask: assert property (
    (!r_reg.supply_gate || !r_reg.power_gate) |=> (regulator_select == '0))
    else $error("regulator on while supply gate clear");
  chk_supply_pass: assert property (
    (r_reg.supply_gate && r_reg.power_gate)
    |=> (regulator_select == $past(r_reg.supply_sel)))
    else $error("regulator select not passed");
  // samples follow the power gate at once, the driver one cycle later
  chk_block_off: assert property (
    !r_reg.power_gate |-> (sample == '0) ##1 !data_pad_oe)
    else $error("pad active while block unpowered");
  chk_reserved_zero: assert property (
    (pready && !pwrite && hit_data) |-> (prdata[31:14] == '0 && prdata[7:2] == '0))
    else $error("reserved bits not zero");
  chk_data_sample: assert property (
    (setup && !pwrite && hit_data) |=> (prdata[DP_SAMPLE] == $past(sample[PAD_DATA])))
    else $error("data pad sample read wrong");
  chk_all_reserved: assert property (
    (pready && !pwrite && hit_all) |-> (prdata[31:6] == '0))
    else $error("all pads reserved bits not zero");

  cov_all_write: cover property (wr_fire && hit_all);
  cov_data_read: cover property (setup && !pwrite && hit_data);
  cov_unmapped: cover property (pready && pslverr);
  cov_supply_on: cover property (regulator_select != '0);
endmodule : scspc_pad_ctrl

// File: scspc_pad_ctrl_tb.sv
// self-checking bench for the smart card synchronous pad control block
`timescale 1ns/100ps
module scspc_pad_ctrl_tb;
  import scspc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_mode_sel;
  logic [31:0] paddr, pwdata, prdata, v, seed;
  logic data_line, data_pad_out, data_pad_oe, data_pad_rx_en, data_pad_pull_up;
  logic data_pad_pull_dn, rst_drive_value, clk_drive_value, c4_drive_value, c8_drive_value;
  logic [1:0] regulator_select;
  logic [3:0] card_lvl, card_pins;
  logic [32:0] exp_q[$];
  int fails, compares, cycles;

  scspc_pad_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_mode_sel(sync_mode_sel), .data_pad_in(data_line),
    .clk_pad_in(card_pins[1]), .rst_pad_in(card_pins[0]), .c4_pad_in(card_pins[2]),
    .c8_pad_in(card_pins[3]), .data_pad_out(data_pad_out), .data_pad_oe(data_pad_oe),
    .data_pad_rx_en(data_pad_rx_en), .data_pad_pull_up(data_pad_pull_up),
    .data_pad_pull_dn(data_pad_pull_dn), .rst_drive_value(rst_drive_value),
    .clk_drive_value(clk_drive_value), .c4_drive_value(c4_drive_value),
    .c8_drive_value(c8_drive_value), .regulator_select(regulator_select));

  scspc_card_model card (.pclk(pclk), .pad_out(data_pad_out), .pad_oe(data_pad_oe),
    .pull_up(data_pad_pull_up), .pull_dn(data_pad_pull_dn), .card_lvl(card_lvl),
    .data_line(data_line), .card_pins(card_pins));

  always #5 pclk = ~pclk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // one idle cycle before each setup keeps every driven signal to one change per step
  task automatic apb(input logic is_wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task automatic settle;
    repeat (4) @(posedge pclk);
    #1;
  endtask : settle

  // answers are compared against the oldest note as they appear
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1ffffffff);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sync_mode_sel = 1'b0;
    card_lvl = 4'h0;
    seed = $urandom(32'he7c6acbc);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_DATA_PAD, RST_DATA_PAD);
    rd(OFF_ALL_PADS, RST_ALL_PADS);
    rd(OFF_BLOCK_CTRL, RST_BLOCK_CTRL);
    apb(1'b0, 32'h000000b0, 32'h0, 33'h100000000);
    $display("test reset values done");
    sync_mode_sel <= 1'b1;
    wr(OFF_BLOCK_CTRL, 32'h00000005);
    wr(OFF_DATA_PAD, 32'h00003000);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      card_lvl <= 4'($urandom);
      wr(OFF_ALL_PADS, v);
      settle();
      chk({c8_drive_value, c4_drive_value, data_pad_out, clk_drive_value, rst_drive_value},
          {28'h0, v[5:1]});
      chk(regulator_select, v[0] ? 33'h2 : 33'h0);
      rd(OFF_ALL_PADS, {26'h0, card_pins[3:2], v[3], card_pins[1:0], v[0]});
    end
    $display("test all pads done");
    wr(OFF_DATA_PAD, 32'hffffc3fe);
    rd(OFF_DATA_PAD, 32'h00000300);
    wr(OFF_DATA_PAD, 32'h00002200);
    settle();
    chk({data_pad_oe, data_pad_rx_en, data_pad_pull_up, data_pad_pull_dn}, 33'h6);
    rd(OFF_DATA_PAD, 32'h00002202);
    wr(OFF_DATA_PAD, 32'h00002101);
    settle();
    chk({data_pad_oe, data_pad_pull_up, data_pad_pull_dn}, 33'h1);
    rd(OFF_DATA_PAD, 32'h00002101);
    $display("test pulls and sample done");
    wr(OFF_DATA_PAD, 32'h00001401);
    settle();
    chk(data_pad_oe, 33'h0);
    wr(OFF_DATA_PAD, 32'h00001400);
    settle();
    chk({data_pad_oe, data_pad_out}, 33'h2);
    wr(OFF_DATA_PAD, 32'h00001800);
    settle();
    chk({data_pad_oe, data_pad_out}, 33'h2);
    wr(OFF_DATA_PAD, 32'h00001801);
    @(posedge pclk);
    #1;
    chk({data_pad_oe, data_pad_out}, 33'h3);
    @(posedge pclk);
    #1;
    chk(data_pad_oe, 33'h0);
    $display("test drive modes done");
    wr(OFF_DATA_PAD, 32'h00003000);
    card_lvl <= 4'hf;
    // pad mux away from synchronous mode: no drive, samples masked
    sync_mode_sel <= 1'b0;
    settle();
    chk(data_pad_oe, 33'h0);
    rd(OFF_ALL_PADS, {31'h0, v[0]});
    sync_mode_sel <= 1'b1;
    wr(OFF_BLOCK_CTRL, 32'h00000004);
    settle();
    chk({data_pad_oe, data_pad_rx_en, regulator_select}, 33'h0);
    rd(OFF_ALL_PADS, {31'h0, v[0]});
    $display("test power gate done");
    close_out();
  end
endmodule : scspc_pad_ctrl_tb

// File: scspc_pin_sync.sv
// two flip-flop synchroniser for the card pad inputs
`timescale 1ns/100ps
module scspc_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [scspc_pkg::NPADS-1:0] pin_in,
  output logic [scspc_pkg::NPADS-1:0] pin_sync
);
  import scspc_pkg::*;
  logic [NPADS-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule : scspc_pin_sync

// File: scspc_pkg.sv
// constants and state types for the smart card synchronous pad control block
package scspc_pkg;
  localparam int APB_AW = 32;
  localparam int APB_DW = 32;
  localparam logic [APB_AW-1:0] OFF_DATA_PAD = 32'h000000a0;
  localparam logic [APB_AW-1:0] OFF_ALL_PADS = 32'h000000a4;
  localparam logic [APB_AW-1:0] OFF_BLOCK_CTRL = 32'h000000a8;
  localparam logic [APB_DW-1:0] RST_DATA_PAD = 32'h00000000;
  localparam logic [APB_DW-1:0] RST_ALL_PADS = 32'h00000000;
  localparam logic [APB_DW-1:0] RST_BLOCK_CTRL = 32'h00000000;
  // data pad register fields
  localparam int DP_RX_GATE = 13;
  localparam int DP_TX_GATE = 12;
  localparam int DP_BOOST = 11;
  localparam int DP_SINK = 10;
  localparam int DP_PULL_UP = 9;
  localparam int DP_PULL_DN = 8;
  localparam int DP_SAMPLE = 1;
  localparam int DP_DRIVE = 0;
  // all pads register fields
  localparam int AP_C8 = 5;
  localparam int AP_C4 = 4;
  localparam int AP_DATA = 3;
  localparam int AP_CLK = 2;
  localparam int AP_RST = 1;
  localparam int AP_SUPPLY = 0;
  // block control register fields
  localparam int BC_POWER = 0;
  localparam int BC_SUP_LSB = 1;
  localparam int SUP_W = 2;
  // pad index in the drive and sample vectors: all pads bit = index + 1
  localparam int NPADS = 5;
  localparam int PAD_DATA = 2;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic out;
    logic oe;
    logic prev;
  } scspc_drv_s;

  typedef struct packed {
    logic rx_gate;
    logic tx_gate;
    logic boost;
    logic sink;
    logic pull_up;
    logic pull_dn;
    logic [NPADS-1:0] drive;
    logic supply_gate;
    logic power_gate;
    logic [SUP_W-1:0] supply_sel;
    logic [SUP_W-1:0] reg_sel;
    logic rx_en;
    logic pu_out;
    logic pd_out;
    logic pready;
    logic pslverr;
    logic [APB_DW-1:0] prdata;
  } scspc_state_s;
endpackage : scspc_pkg
